// *** verilog/fnsr_pkg.sv ***
// Package for the synthesizer programming register bank: select codes,
// field positions, legal limits and reset values.
// Assumes a 24-bit serial word, shifted in most significant bit first.
package fnsr_pkg;

  localparam int WORD_W = 24;
  localparam int CODE_W = 3;

  // Register select codes in the low three bits of every word
  typedef enum logic [2:0] {
    SEL_FREQ    = 3'b000,
    SEL_MODREF  = 3'b001,
    SEL_PHASE   = 3'b010,
    SEL_FUNC    = 3'b011,
    SEL_TIMEOUT = 3'b100
  } fnsr_sel_e;

  // Fast-lock sequencer states
  typedef enum logic [1:0] {
    LK_IDLE  = 2'b00,
    LK_ARMED = 2'b01,
    LK_FAST  = 2'b10
  } fnsr_lock_e;

  // Frequency word fields
  localparam int INT_LSB = 15;
  localparam int INT_W = 8;
  localparam int FRACTION_NUMERATOR_LSB = 3;
  localparam int FRACTION_NUMERATOR_W = 12;
  // Modulus and reference setup fields
  localparam int MOD_LSB = 3;
  localparam int RCNT_LSB = 16;
  localparam int RCNT_W = 4;
  localparam int DBL_BIT = 20;
  localparam int HALVE_BIT = 22;
  localparam int BOOST_BIT = 23;
  // Phase seed field
  localparam int PHASE_LSB = 3;
  // Function setup fields
  localparam int POL_BIT = 3;
  localparam int GND_BIT = 5;
  // Timeout register fields
  localparam int TSEL_LSB = 3;
  localparam int TSEL_W = 2;
  localparam int TVAL_LSB = 5;
  localparam int TVAL_W = 9;

  // Timer select codes
  localparam logic [1:0] TSEL_PUMP = 2'b10;
  localparam logic [1:0] TSEL_SW12 = 2'b01;
  localparam logic [1:0] TSEL_SW3 = 2'b00;

  // Legal lower limits
  localparam logic [7:0] INT_MIN = 8'h1a;
  localparam logic [11:0] MOD_MIN = 12'h00d;
  localparam logic [3:0] RCNT_MIN = 4'h1;

  // Pump current ramp: 64x is a shift of six, unity a shift of zero
  localparam logic [2:0] PUMP_SHIFT_MAX = 3'h6;
  // Timer prescale: last phase detector tick of each group of four
  localparam logic [1:0] QUARTER_LAST = 2'h3;

  // Reset values
  localparam logic [7:0] RST_INT = 8'h1a;
  localparam logic [11:0] RST_FRACTION_NUMERATOR = 12'h000;
  localparam logic [11:0] RST_MOD = 12'h00d;
  localparam logic [3:0] RST_RCNT = 4'h1;
  localparam logic [11:0] RST_PHASE = 12'h000;
  localparam logic [8:0] RST_TVAL = 9'h000;

endpackage

// *** verilog/fnsr_timer_if.sv ***
// Interface between the register bank and one fast-lock timeout counter.
// Assumes both ends share core_clk.
`timescale 1ns/100ps
`default_nettype none
interface fnsr_timer_if #(parameter int TW = 9);
  logic start;
  logic [TW-1:0] value;
  logic expired;
  modport timer (input start, input value, output expired);
  modport ctrl (output start, output value, input expired);
endinterface
`default_nettype wire

// *** verilog/fnsr_fast_timer.sv ***
// One fast-lock timeout counter, counting at a quarter of the phase
// detector rate. Assumes pd_tick is a one-cycle pulse per detector cycle.
`timescale 1ns/100ps
`default_nettype none
module fnsr_fast_timer #(
  parameter int TW = 9
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic pd_tick,
  fnsr_timer_if.timer tif
);

  logic [TW-1:0] count_ff;
  logic [1:0] pre_ff;
  logic run_ff;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      count_ff <= '0;
      pre_ff <= '0;
      run_ff <= 1'b0;
    end else if (clk_en) begin
      if (tif.start) begin
        count_ff <= tif.value;
        pre_ff <= '0;
        run_ff <= 1'b1;
      end else if (run_ff) begin
        if (count_ff == '0) begin
          run_ff <= 1'b0; // Value zero expires at once
        end else if (pd_tick) begin
          if (pre_ff == fnsr_pkg::QUARTER_LAST) begin
            pre_ff <= '0;
            count_ff <= count_ff - 1'b1;
          end else begin
            pre_ff <= pre_ff + 1'b1;
          end
        end
      end
    end
  end

  // Open until first started, so switches stay open after reset
  assign tif.expired = !run_ff;

  // One decrement per four detector ticks
  a_quarter_step: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && run_ff && !tif.start && count_ff != '0 && pd_tick && pre_ff == fnsr_pkg::QUARTER_LAST)
      |=> (count_ff == $past(count_ff) - 1'b1))
    else $error("timeout counter missed its quarter-rate step");

  a_start_load: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && tif.start) |=> (run_ff && count_ff == $past(tif.value)))
    else $error("timeout counter did not load on start");

endmodule // fnsr_fast_timer
`default_nettype wire

// *** verilog/fnsr_program_regs.sv ***
// Programming register bank of a fractional-N synthesizer: serial word
// capture, decode, double buffering and fast-lock sequencing.
// Assumes serial pins and pd_tick are synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Low three word bits pick the register: 000 freq, 001 modulus, 011 function.
// - Integer field legal from 26 to 255; smaller words are refused.
// - Fraction legal from zero to modulus minus one.
// - Modulus, reference count, halving, boost, doubler apply at next freq write.
// - Boost bit raises pump current a quarter from next freq write.
// - Halving bit inserts divide-by-two before the phase detector.
// - Doubler bit places a doubler ahead of the reference divider.
// - Reference count legal from 1 to 15.
// - Modulus legal from 13 to 4095.
// - Phase seed legal from zero to modulus, steps a turn over modulus.
// - Phase seed waits for the next frequency word load strobe.
// - Grounding bit low pulls pump outputs to ground.
// - Polarity bit one positive, zero negative.
// - Timeout counts at quarter detector rate: value times four periods.
// - Timer select 10 pump, 01 switches one and two, 00 switch three.
// - Freq write starts timers; pump steps 64x down to unity in six steps.
// - First detector cycle after freq write loads divider, starts fast lock.
module fnsr_program_regs #(
  parameter int TW = 9
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic pd_tick,
  output logic [7:0] int_value,
  output logic [11:0] fraction_numerator,
  output logic divider_load,
  output logic [11:0] fraction_modulus,
  output logic [3:0] ref_count,
  output logic ref_halve,
  output logic ref_doubler,
  output logic pump_current_boost,
  output logic [11:0] phase_seed,
  output logic pump_output_grounded,
  output logic pd_polarity_pos,
  output logic loop_switch_one,
  output logic loop_switch_two,
  output logic loop_switch_three,
  output logic [2:0] pump_gain_shift,
  output logic fast_lock_active,
  output logic word_refused
);

  // Field extraction used by the fraction, modulus and phase decodes
  function automatic logic [11:0] field12(input logic [fnsr_pkg::WORD_W-1:0] w, input int lsb);
    field12 = w[lsb +: 12];
  endfunction

  logic sclk_q_ff;
  logic le_q_ff;
  logic [fnsr_pkg::WORD_W-1:0] shift_ff;
  logic sclk_rise;
  logic le_rise;
  logic [fnsr_pkg::CODE_W-1:0] code;
  logic [7:0] w_int;
  logic [11:0] w_fraction_numerator;
  logic [11:0] w_mod;
  logic [3:0] w_rcnt;
  logic [11:0] w_phase;
  logic [1:0] w_tsel;
  logic [TW-1:0] w_tval;
  logic freq_ok;
  logic mod_ok;
  logic phase_ok;
  logic freq_accept;
  logic mod_accept;
  logic phase_accept;
  logic func_accept;
  logic tout_accept;
  logic [11:0] sh_mod_ff;
  logic [3:0] sh_rcnt_ff;
  logic sh_halve_ff;
  logic sh_boost_ff;
  logic sh_dbl_ff;
  logic [11:0] sh_phase_ff;
  logic [7:0] pend_int_ff;
  logic [11:0] pend_fraction_numerator_ff;
  logic [TW-1:0] tv_pump_ff;
  logic [TW-1:0] tv_sw12_ff;
  logic [TW-1:0] tv_sw3_ff;
  logic gnd_bit_ff;
  fnsr_pkg::fnsr_lock_e lock_ff;
  fnsr_pkg::fnsr_lock_e nxt_lock;
  logic timer_start;

  fnsr_timer_if #(.TW(TW)) pump_if ();
  fnsr_timer_if #(.TW(TW)) sw12_if ();
  fnsr_timer_if #(.TW(TW)) sw3_if ();

  // Pin edge history; pins are already in the core_clk domain
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sclk_q_ff <= 1'b0;
      le_q_ff <= 1'b0;
    end else if (clk_en) begin
      sclk_q_ff <= serial_clk;
      le_q_ff <= load_strobe;
    end
  end

  assign sclk_rise = serial_clk && !sclk_q_ff;
  assign le_rise = load_strobe && !le_q_ff;

  // Shift in MSB first while the strobe is low; short words land low
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      shift_ff <= '0;
    end else if (clk_en && sclk_rise && !load_strobe) begin
      shift_ff <= {shift_ff[fnsr_pkg::WORD_W-2:0], serial_data};
    end
  end

  // Field views of the captured word
  assign code = shift_ff[fnsr_pkg::CODE_W-1:0];
  assign w_int = shift_ff[fnsr_pkg::INT_LSB +: fnsr_pkg::INT_W];
  assign w_fraction_numerator = field12(shift_ff, fnsr_pkg::FRACTION_NUMERATOR_LSB);
  assign w_mod = field12(shift_ff, fnsr_pkg::MOD_LSB);
  assign w_rcnt = shift_ff[fnsr_pkg::RCNT_LSB +: fnsr_pkg::RCNT_W];
  assign w_phase = field12(shift_ff, fnsr_pkg::PHASE_LSB);
  assign w_tsel = shift_ff[fnsr_pkg::TSEL_LSB +: fnsr_pkg::TSEL_W];
  assign w_tval = shift_ff[fnsr_pkg::TVAL_LSB +: TW];

  // legality; fraction is judged against the modulus it will meet
  assign freq_ok = (w_int >= fnsr_pkg::INT_MIN) && (w_fraction_numerator < sh_mod_ff);
  assign mod_ok = (w_mod >= fnsr_pkg::MOD_MIN) && (w_rcnt >= fnsr_pkg::RCNT_MIN);
  assign phase_ok = (w_phase <= sh_mod_ff);

  always_comb begin
    freq_accept = 1'b0;
    mod_accept = 1'b0;
    phase_accept = 1'b0;
    func_accept = 1'b0;
    tout_accept = 1'b0;
    if (le_rise) begin
      unique case (code)
        fnsr_pkg::SEL_FREQ: freq_accept = freq_ok;
        fnsr_pkg::SEL_MODREF: mod_accept = mod_ok;
        fnsr_pkg::SEL_PHASE: phase_accept = phase_ok;
        fnsr_pkg::SEL_FUNC: func_accept = 1'b1;
        fnsr_pkg::SEL_TIMEOUT: tout_accept = 1'b1;
        default: ; // Registers outside this bank
      endcase
    end
  end

  // Refusal pulse for out-of-range words in this bank's registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      word_refused <= 1'b0;
    end else if (clk_en) begin
      word_refused <= le_rise && ((code == fnsr_pkg::SEL_FREQ && !freq_ok) ||
                                  (code == fnsr_pkg::SEL_MODREF && !mod_ok) ||
                                  (code == fnsr_pkg::SEL_PHASE && !phase_ok));
    end
  end

  // shadow copies, written by their own words only
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sh_mod_ff <= fnsr_pkg::RST_MOD;
      sh_rcnt_ff <= fnsr_pkg::RST_RCNT;
      sh_halve_ff <= 1'b0;
      sh_boost_ff <= 1'b0;
      sh_dbl_ff <= 1'b0;
      sh_phase_ff <= fnsr_pkg::RST_PHASE;
    end else if (clk_en) begin
      if (mod_accept) begin
        sh_mod_ff <= w_mod;
        sh_rcnt_ff <= w_rcnt;
        sh_halve_ff <= shift_ff[fnsr_pkg::HALVE_BIT];
        sh_boost_ff <= shift_ff[fnsr_pkg::BOOST_BIT];
        sh_dbl_ff <= shift_ff[fnsr_pkg::DBL_BIT];
      end
      if (phase_accept) begin
        sh_phase_ff <= w_phase;
      end
    end
  end

  // shadows take effect at the freq word strobe
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fraction_modulus <= fnsr_pkg::RST_MOD;
      ref_count <= fnsr_pkg::RST_RCNT;
      ref_halve <= 1'b0;
      ref_doubler <= 1'b0;
      pump_current_boost <= 1'b0;
      phase_seed <= fnsr_pkg::RST_PHASE;
      pend_int_ff <= fnsr_pkg::RST_INT;
      pend_fraction_numerator_ff <= fnsr_pkg::RST_FRACTION_NUMERATOR;
    end else if (clk_en && freq_accept) begin
      fraction_modulus <= sh_mod_ff;
      ref_count <= sh_rcnt_ff;
      ref_halve <= sh_halve_ff;
      ref_doubler <= sh_dbl_ff;
      pump_current_boost <= sh_boost_ff;
      phase_seed <= sh_phase_ff;
      pend_int_ff <= w_int;
      pend_fraction_numerator_ff <= w_fraction_numerator;
    end
  end

  // function setup; grounded until software lifts it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      gnd_bit_ff <= 1'b0;
      pd_polarity_pos <= 1'b1;
    end else if (clk_en && func_accept) begin
      gnd_bit_ff <= shift_ff[fnsr_pkg::GND_BIT];
      pd_polarity_pos <= shift_ff[fnsr_pkg::POL_BIT];
    end
  end

  assign pump_output_grounded = !gnd_bit_ff;

  // timeout value routing by timer select
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tv_pump_ff <= fnsr_pkg::RST_TVAL;
      tv_sw12_ff <= fnsr_pkg::RST_TVAL;
      tv_sw3_ff <= fnsr_pkg::RST_TVAL;
    end else if (clk_en && tout_accept) begin
      if (w_tsel == fnsr_pkg::TSEL_PUMP) begin
        tv_pump_ff <= w_tval;
      end else if (w_tsel == fnsr_pkg::TSEL_SW12) begin
        tv_sw12_ff <= w_tval;
      end else if (w_tsel == fnsr_pkg::TSEL_SW3) begin
        tv_sw3_ff <= w_tval;
      end
    end
  end

  // arm on accepted freq word, fire on next detector tick
  always_comb begin
    nxt_lock = lock_ff;
    unique case (lock_ff)
      fnsr_pkg::LK_IDLE: if (freq_accept) nxt_lock = fnsr_pkg::LK_ARMED;
      fnsr_pkg::LK_ARMED: if (pd_tick && !freq_accept) nxt_lock = fnsr_pkg::LK_FAST;
      fnsr_pkg::LK_FAST: begin
        if (freq_accept) begin
          nxt_lock = fnsr_pkg::LK_ARMED;
        end else if (pump_if.expired && sw12_if.expired && sw3_if.expired &&
                     pump_gain_shift == 3'h0) begin
          nxt_lock = fnsr_pkg::LK_IDLE;
        end
      end
      default: nxt_lock = fnsr_pkg::LK_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lock_ff <= fnsr_pkg::LK_IDLE;
    end else if (clk_en) begin
      lock_ff <= nxt_lock;
    end
  end

  assign timer_start = clk_en && lock_ff == fnsr_pkg::LK_ARMED && nxt_lock == fnsr_pkg::LK_FAST;
  assign fast_lock_active = (lock_ff == fnsr_pkg::LK_FAST);

  // divider takes the new integer and fraction with the start
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      int_value <= fnsr_pkg::RST_INT;
      fraction_numerator <= fnsr_pkg::RST_FRACTION_NUMERATOR;
      divider_load <= 1'b0;
    end else if (clk_en) begin
      divider_load <= timer_start;
      if (timer_start) begin
        int_value <= pend_int_ff;
        fraction_numerator <= pend_fraction_numerator_ff;
      end
    end
  end

  assign pump_if.start = timer_start;
  assign pump_if.value = tv_pump_ff;
  assign sw12_if.start = timer_start;
  assign sw12_if.value = tv_sw12_ff;
  assign sw3_if.start = timer_start;
  assign sw3_if.value = tv_sw3_ff;

  fnsr_fast_timer #(.TW(TW)) u_pump_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pd_tick(pd_tick),
    .tif(pump_if)
  );

  fnsr_fast_timer #(.TW(TW)) u_sw12_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pd_tick(pd_tick),
    .tif(sw12_if)
  );

  fnsr_fast_timer #(.TW(TW)) u_sw3_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pd_tick(pd_tick),
    .tif(sw3_if)
  );

  // switches closed while fast lock runs and their timer holds
  assign loop_switch_one = fast_lock_active && !sw12_if.expired;
  assign loop_switch_two = fast_lock_active && !sw12_if.expired;
  assign loop_switch_three = fast_lock_active && !sw3_if.expired;

  // pump ramp: one binary step per detector tick after expiry
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pump_gain_shift <= 3'h0;
    end else if (clk_en) begin
      if (timer_start) begin
        pump_gain_shift <= fnsr_pkg::PUMP_SHIFT_MAX;
      end else if (fast_lock_active && pump_if.expired && pd_tick && pump_gain_shift != 3'h0) begin
        pump_gain_shift <= pump_gain_shift - 1'b1;
      end
    end
  end

  // Checks beside the logic
  a_freq_select: assert property (@(posedge core_clk) disable iff (!reset_n)
    (freq_accept && clk_en) |=> (lock_ff == fnsr_pkg::LK_ARMED))
    else $error("accepted frequency word did not arm fast lock");

  a_int_legal: assert property (@(posedge core_clk) disable iff (!reset_n)
    int_value >= fnsr_pkg::INT_MIN)
    else $error("integer value below legal range");

  a_fraction_numerator_legal: assert property (@(posedge core_clk) disable iff (!reset_n)
    divider_load |-> (fraction_numerator < fraction_modulus))
    else $error("fraction not below modulus at divider load");

  a_shadow_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    !freq_accept |=> ($stable(fraction_modulus) && $stable(ref_count) && $stable(phase_seed)))
    else $error("buffered setting changed without a frequency word");

  a_boost_apply: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && freq_accept) |=> (pump_current_boost == $past(sh_boost_ff)))
    else $error("pump boost not applied at frequency word");

  a_ref_legal: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ref_count >= fnsr_pkg::RCNT_MIN) && (fraction_modulus >= fnsr_pkg::MOD_MIN))
    else $error("reference count or modulus out of range");

  a_grounding: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && func_accept) |=> (pump_output_grounded == !$past(shift_ff[fnsr_pkg::GND_BIT])))
    else $error("grounding output does not follow setup bit");

  a_timer_route: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && tout_accept && w_tsel == fnsr_pkg::TSEL_PUMP) |=> (tv_pump_ff == $past(w_tval)))
    else $error("pump timeout value not routed");

  a_ramp_step: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && !timer_start && fast_lock_active && pump_if.expired && pd_tick && pump_gain_shift != 3'h0)
      |=> (pump_gain_shift == $past(pump_gain_shift) - 1'b1))
    else $error("pump current ramp missed a step");

  a_divider_load: assert property (@(posedge core_clk) disable iff (!reset_n)
    timer_start |=> (divider_load && fast_lock_active && pump_gain_shift == fnsr_pkg::PUMP_SHIFT_MAX))
    else $error("fast lock did not start on detector tick");

endmodule // fnsr_program_regs
`default_nettype wire

// *** verif/fnsr_host_model.sv ***
// Host controller model: builds words and shifts them out MSB first.
// Assumes the bank samples the serial pins on core_clk.
`timescale 1ns/100ps
`default_nettype none
module fnsr_host_model (
  input wire logic core_clk,
  output logic serial_clk,
  output logic serial_data,
  output logic load_strobe
);
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end

  // Edge count for strobe alignment; non-blocking so tasks read a settled count
  int cyc = 0;
  always @(posedge core_clk) cyc <= cyc + 1;

  function automatic logic [23:0] w_freq(input int n, input int f);
    return {1'b0, n[7:0], f[11:0], 3'b000};
  endfunction

  // bit 21 and bit 15 zero
  function automatic logic [23:0] w_mod(input int m, input int r, input int h, input int d, input int b);
    return {b[0], h[0], 1'b0, d[0], r[3:0], 1'b0, m[11:0], 3'b001};
  endfunction

  function automatic logic [23:0] w_phase(input int p);
    return {8'h00, 1'b0, p[11:0], 3'b010};
  endfunction

  function automatic logic [23:0] w_func(input bit g, input bit p);
    return {8'h00, 10'h001, g, 1'b1, p, 3'b011};
  endfunction

  function automatic logic [23:0] w_tmo(input int v, input logic [1:0] s);
    return {10'h001, v[8:0], s, 3'b100};
  endfunction

  // code goes out last; link clock idles low, data inverts once released
  task automatic send(input logic [23:0] w, input int slow, input int align);
    for (int i = 23; i >= 0; i--) begin
      serial_data <= w[i];
      serial_clk <= 1'b0;
      repeat (2 + slow) @(posedge core_clk);
      serial_clk <= 1'b1;
      repeat (2 + slow) @(posedge core_clk);
    end
    serial_clk <= 1'b0;
    serial_data <= ~w[0];
    repeat (2) @(posedge core_clk);
    // strobe on a reference-cycle boundary, whole modulus counts apart
    while (align > 0 && cyc % align != 0) @(posedge core_clk);
    load_strobe <= 1'b1;
    repeat (2) @(posedge core_clk);
    load_strobe <= 1'b0;
    @(posedge core_clk);
  endtask
endmodule // fnsr_host_model
`default_nettype wire

// *** verif/tb_fnsr_program_regs.sv ***
// Self-checking bench for the synthesizer programming register bank.
// Assumes the host model owns the serial pins; pd_tick pulses every fourth cycle.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) check_eq((a), (b));
module tb_fnsr_program_regs;
  logic core_clk, serial_clk, serial_data, load_strobe;
  logic reset_n = 1'b0, clk_en = 1'b1, pd_tick = 1'b0;
  logic [7:0] int_value;
  logic [11:0] fraction_numerator, fraction_modulus, phase_seed;
  logic [3:0] ref_count;
  logic [2:0] pump_gain_shift, sw_q = 3'h0, sh_q = 3'h0;
  logic divider_load, ref_halve, ref_doubler, pump_current_boost, pump_output_grounded;
  logic pd_polarity_pos, loop_switch_one, loop_switch_two, loop_switch_three, fast_lock_active, word_refused;
  logic [31:0] rnd = 32'hc560;
  int num_errors = 0, comparisons = 0, cycles = 0, refused = 0, dl = 0, tk = 0, ramp = 0, t_ramp = 0;
  int m_ref = 0, m_dl = 0, m_int = 26, m_fraction_numerator = 0;
  int at[3];
  int sh[6] = '{13, 1, 0, 0, 0, 0};
  int ac[6] = '{13, 1, 0, 0, 0, 0};
  wire [2:0] sw = {loop_switch_three, loop_switch_two, loop_switch_one};

  fnsr_program_regs #(.TW(9)) dut (.core_clk, .reset_n, .clk_en, .serial_clk, .serial_data, .load_strobe,
    .pd_tick, .int_value, .fraction_numerator, .divider_load, .fraction_modulus, .ref_count, .ref_halve,
    .ref_doubler, .pump_current_boost, .phase_seed, .pump_output_grounded, .pd_polarity_pos, .loop_switch_one,
    .loop_switch_two, .loop_switch_three, .pump_gain_shift, .fast_lock_active, .word_refused);
  fnsr_host_model host (.core_clk, .serial_clk, .serial_data, .load_strobe);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Hang guard; the whole run needs well under this
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    results();
  end

  // Detector ticks, pulse counts and fast-lock timing measured in ticks
  always @(posedge core_clk) begin
    cycles++;
    pd_tick <= (cycles % 4 == 0);
    if (word_refused === 1'b1) refused++;
    if (divider_load === 1'b1) begin
      dl++;
      tk = 0;
      ramp = 0;
      at = '{-9, -9, -9};
    end else if (pd_tick === 1'b1 && clk_en === 1'b1) tk++;
    for (int i = 0; i < 3; i++) if (sw_q[i] === 1'b1 && sw[i] === 1'b0) at[i] = tk;
    if (pump_gain_shift === sh_q - 3'h1) begin
      ramp++;
      if (ramp == 1) t_ramp = tk;
    end
    sw_q = sw;
    sh_q = pump_gain_shift;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic bit near(input int a, input int b);
    return a >= b - 1 && a <= b + 1;
  endfunction

  task automatic check_eq(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_regs;
    `CHK(fraction_modulus, ac[0])
    `CHK(ref_count, ac[1])
    `CHK(ref_halve, ac[2])
    `CHK(ref_doubler, ac[3])
    `CHK(pump_current_boost, ac[4])
    `CHK(phase_seed, ac[5])
    `CHK(int_value, m_int)
    `CHK(fraction_numerator, m_fraction_numerator)
    `CHK(refused, m_ref)
    `CHK(dl, m_dl)
  endtask

  // Random link speed keeps both prompt and slow hosts in play
  task automatic put(input logic [23:0] w);
    rnd = lfsr(rnd);
    host.send(w, int'(rnd[1:0]), 0);
    repeat (2) @(posedge core_clk);
  endtask

  task automatic modw(input int m, input int r, input int h, input int d, input int b);
    put(host.w_mod(m, r, h, d, b));
    if (m >= 13 && r >= 1) sh = '{m, r, h, d, b, sh[5]};
    else m_ref++;
    chk_regs();
  endtask

  task automatic phw(input int p);
    put(host.w_phase(p));
    if (p <= sh[0]) sh[5] = p;
    else m_ref++;
    chk_regs();
  endtask

  // Shadow copies move to the outputs only on an accepted frequency word
  task automatic freq(input int n, input int f);
    rnd = lfsr(rnd);
    host.send(host.w_freq(n, f), int'(rnd[1:0]), 4 * sh[0]);
    if (n >= 26 && f < sh[0]) begin
      ac = sh;
      m_int = n;
      m_fraction_numerator = f;
      m_dl++;
      for (int i = 0; i < 20 && divider_load !== 1'b1; i++) @(posedge core_clk);
      `CHK({sw, pump_gain_shift, fast_lock_active}, 7'h7d)
    end else m_ref++;
    repeat (2) @(posedge core_clk);
    chk_regs();
  endtask

  task automatic settle(input int vp, input int v12, input int v3);
    for (int i = 0; i < 400 && fast_lock_active !== 1'b0; i++) @(posedge core_clk);
    `CHK(fast_lock_active, 1'b0)
    `CHK(near(at[0], 4 * v12), 1'b1)
    `CHK(near(at[1], 4 * v12), 1'b1)
    `CHK(near(at[2], 4 * v3), 1'b1)
    `CHK(near(t_ramp, 4 * vp + 1), 1'b1)
    `CHK(ramp, 6)
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk_regs();
    `CHK({pump_output_grounded, pd_polarity_pos, fast_lock_active}, 3'b110)
    // setup written three times, both levels of each bit seen
    put(host.w_func(1, 0));
    `CHK({pump_output_grounded, pd_polarity_pos}, 2'b00)
    put(host.w_func(0, 1));
    `CHK({pump_output_grounded, pd_polarity_pos}, 2'b11)
    put(host.w_func(1, 1));
    // Every timer select, then an unused code that must do nothing
    put(host.w_tmo(2, fnsr_pkg::TSEL_PUMP));
    put(host.w_tmo(4, fnsr_pkg::TSEL_SW12));
    put(host.w_tmo(5, fnsr_pkg::TSEL_SW3));
    put(24'h000005);
    chk_regs();
    // Range edges; legal values stay buffered until the frequency word
    modw(12, 1, 0, 0, 0);
    modw(4095, 0, 0, 0, 0);
    modw(100, 15, 1, 1, 1);
    phw(101);
    phw(100);
    freq(25, 5);
    freq(255, 100);
    freq(255, 99);
    settle(2, 4, 5);
    // Zero pump timeout and a random channel at the smallest modulus
    put(host.w_tmo(0, fnsr_pkg::TSEL_PUMP));
    put(host.w_tmo(3, fnsr_pkg::TSEL_SW12));
    put(host.w_tmo(1, fnsr_pkg::TSEL_SW3));
    modw(13, 1, 0, 0, 0);
    phw(13);
    rnd = lfsr(rnd);
    freq(26 + int'(rnd[15:0]) % 230, int'(rnd[27:16]) % 13);
    // Enable low mid fast lock: timers, ramp and switches must all hold
    clk_en <= 1'b0;
    repeat (8) @(posedge core_clk);
    `CHK({sw, pump_gain_shift, fast_lock_active}, 7'h7d)
    clk_en <= 1'b1;
    settle(0, 3, 1);
    results();
  end
endmodule // tb_fnsr_program_regs
`default_nettype wire
